// File: key_field_pkg.sv
package key_field_pkg;
    localparam int PORT_BITMAP_W = 53;
    localparam int PORT_NUM_W = 6;
    localparam int PIPE_PT_W = 5;
    localparam int PIPE_ACT_W = 3;
    localparam int MAC_W = 48;
    localparam int VID_W = 12;
    localparam int PCP_W = 3;
    localparam int PROTO_W = 3;
    localparam int ETYPE_W = 16;
    // mode 3 field positions
    localparam int SEL3_PROC_A_BIT = 0;
    localparam int SEL3_PROC_B_BIT = 1;
    localparam int SEL3_VDEV_A_BIT = 2;
    localparam int SEL3_VDEV_B_BIT = 3;
    localparam int SEL3_SRC_LO = 4;
    localparam int SEL3_PT_LO = 44;
    localparam int SEL3_ACT_LO = 49;
    localparam int MAC_GROUP_BIT = 40;
    localparam logic [ETYPE_W-1:0] TPID_CTAG = 16'h8100;
    localparam logic [ETYPE_W-1:0] TPID_STAG = 16'h88a8;
    localparam logic [ETYPE_W-1:0] ETYPE_MIN = 16'h0600;
    localparam logic [3:0] IP4_MC_NIBBLE = 4'he;
    localparam logic [7:0] IP6_MC_BYTE = 8'hff;
    localparam logic [PROTO_W-1:0] PROTO_NONE = 3'h0;
    localparam logic [PROTO_W-1:0] PROTO_CTAG = 3'h1;
    localparam logic [PROTO_W-1:0] PROTO_STAG = 3'h4;
    localparam logic [PROTO_W-1:0] PROTO_CUST1 = 3'h5;
    localparam logic [PROTO_W-1:0] PROTO_CUST2 = 3'h6;
    localparam logic [PROTO_W-1:0] PROTO_CUST3 = 3'h7;
    typedef enum logic [1:0] {
        SEL_PHYS = 2'b00,
        SEL_LOOP = 2'b01,
        SEL_MASQ = 2'b10,
        SEL_SRC = 2'b11
    } bitmap_sel_t;
endpackage

// File: tag_proto_coder.sv
`timescale 1ns/1ps
`default_nettype none
module tag_proto_coder (
    // tag as seen in frame
    input wire logic present,
    input wire logic [key_field_pkg::ETYPE_W-1:0] tpid,
    // configurable custom values
    input wire logic [key_field_pkg::ETYPE_W-1:0] custom1,
    input wire logic [key_field_pkg::ETYPE_W-1:0] custom2,
    input wire logic [key_field_pkg::ETYPE_W-1:0] custom3,
    // code
    output logic [key_field_pkg::PROTO_W-1:0] code
);
    import key_field_pkg::*;
    // codes 2 and 3 never appear; standard values win over custom ones
    always_comb begin
        code = PROTO_NONE;
        if (present) begin
            if (tpid == TPID_CTAG) begin
                code = PROTO_CTAG;
            end else if (tpid == TPID_STAG) begin
                code = PROTO_STAG;
            end else if (tpid == custom1) begin
                code = PROTO_CUST1;
            end else if (tpid == custom2) begin
                code = PROTO_CUST2;
            end else if (tpid == custom3) begin
                code = PROTO_CUST3;
            end
        end
    end
endmodule
`default_nettype wire

// File: frame_key_field_builder.sv
// Notes on behaviour
// - bitmap is 53 bits; selector 0 sets the arrival port bit
// - selector 1 sets the bit of the port the frame looped on
// - selector 2 sets the bit of the masqueraded source port
// - selector 3 bits 0..3 flag processor ports a,b and virtual devices a,b
// - selector 3: source port bits 4..9, point 44..48, action 49..51
// - group flag follows destination MAC bit 40
// - all-ones flag set only for the broadcast destination MAC
// - outer protocol code: 0 none, 1 ctag, 4 stag, 5..7 custom
// - second tag protocol code uses same coding, 0 means absent or tpid matching no standard or custom value
// - third tag protocol code uses same coding, 0 means absent or tpid matching no standard or custom value
// - outer priority, drop, vlan from frame or classified when enabled
// - untagged frames give outer vlan id zero
// - second and third tag fields always taken from the frame
// - ip group flag: IPv4 top nibble e, IPv6 top byte ff
// - type encoded flag set when type/length is at least 0x600
// - selector 1 loopback, 2 masquerade enabled, 3 inject/vdev/loop enabled
// - when several selector criteria hold, the highest value wins
`timescale 1ns/1ps
`default_nettype none
module frame_key_field_builder #(
    parameter int NUM_PORTS = key_field_pkg::PORT_BITMAP_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // frame metadata from parser
    input wire logic frame_valid,
    input wire logic [key_field_pkg::PORT_NUM_W-1:0] arrival_port,
    input wire logic [key_field_pkg::PORT_NUM_W-1:0] loop_port,
    input wire logic [key_field_pkg::PORT_NUM_W-1:0] masq_port,
    input wire logic from_loopback,
    input wire logic is_masqueraded,
    input wire logic is_injected,
    input wire logic from_virtual_device,
    input wire logic is_processor_port_a,
    input wire logic is_processor_port_b,
    input wire logic is_virtual_device_a,
    input wire logic is_virtual_device_b,
    input wire logic [key_field_pkg::PIPE_PT_W-1:0] pipeline_point,
    input wire logic [key_field_pkg::PIPE_ACT_W-1:0] pipeline_action,
    // configuration
    input wire logic masq_bitmap_ena,
    input wire logic proc_bitmap_ena,
    input wire logic vdev_bitmap_ena,
    input wire logic loop_sel3_ena,
    input wire logic use_classified_outer_tci,
    input wire logic [key_field_pkg::ETYPE_W-1:0] custom_tag1,
    input wire logic [key_field_pkg::ETYPE_W-1:0] custom_tag2,
    input wire logic [key_field_pkg::ETYPE_W-1:0] custom_tag3,
    // frame fields
    input wire logic [key_field_pkg::MAC_W-1:0] frame_dmac,
    input wire logic [key_field_pkg::MAC_W-1:0] frame_smac,
    input wire logic [2:0] tag_present,
    input wire logic [3*key_field_pkg::ETYPE_W-1:0] tag_tpid,
    input wire logic [3*key_field_pkg::ETYPE_W-1:0] tag_tci,
    input wire logic [key_field_pkg::PCP_W-1:0] classified_priority,
    input wire logic classified_drop_eligible,
    input wire logic [key_field_pkg::VID_W-1:0] classified_vlan_id,
    input wire logic frame_is_ipv4,
    input wire logic frame_is_ipv6,
    input wire logic [7:0] ip_dest_top_byte,
    input wire logic [key_field_pkg::ETYPE_W-1:0] type_length,
    // key fields
    output logic key_valid,
    output key_field_pkg::bitmap_sel_t port_bitmap_selector,
    output logic [NUM_PORTS-1:0] ingress_port_bitmap,
    output logic dest_mac_group_flag,
    output logic dest_mac_all_ones_flag,
    output logic [key_field_pkg::PROTO_W-1:0] outer_tag_proto_code,
    output logic [key_field_pkg::PCP_W-1:0] outer_tag_priority,
    output logic outer_tag_drop_eligible,
    output logic [key_field_pkg::VID_W-1:0] outer_tag_vlan_id,
    output logic [key_field_pkg::PROTO_W-1:0] second_tag_proto_code,
    output logic [key_field_pkg::PCP_W-1:0] second_tag_priority,
    output logic second_tag_drop_eligible,
    output logic [key_field_pkg::VID_W-1:0] second_tag_vlan_id,
    output logic [key_field_pkg::PROTO_W-1:0] third_tag_proto_code,
    output logic [key_field_pkg::PCP_W-1:0] third_tag_priority,
    output logic third_tag_drop_eligible,
    output logic [key_field_pkg::VID_W-1:0] third_tag_vlan_id,
    output logic [key_field_pkg::MAC_W-1:0] dest_mac_field,
    output logic [key_field_pkg::MAC_W-1:0] source_mac_field,
    output logic ip_group_dest_flag,
    output logic type_encoded_flag
);
    import key_field_pkg::*;

    localparam int TCI_VID_LO = 0;
    localparam int TCI_DEI_BIT = 12;
    localparam int TCI_PCP_LO = 13;

    bitmap_sel_t nxt_sel;
    logic [NUM_PORTS-1:0] nxt_bitmap;
    logic [PROTO_W-1:0] code [3];
    logic [PCP_W-1:0] tag_pcp [3];
    logic tag_dei [3];
    logic [VID_W-1:0] tag_vid [3];

    // highest applicable selector wins, so test from 3 downward
    always_comb begin
        if ((is_injected && proc_bitmap_ena) ||
            (from_virtual_device && vdev_bitmap_ena) ||
            (from_loopback && loop_sel3_ena)) begin
            nxt_sel = SEL_SRC;
        end else if (is_masqueraded && masq_bitmap_ena) begin
            nxt_sel = SEL_MASQ;
        end else if (from_loopback) begin
            nxt_sel = SEL_LOOP;
        end else begin
            nxt_sel = SEL_PHYS;
        end
    end

    // ports beyond the bitmap width simply set no bit
    always_comb begin
        nxt_bitmap = '0;
        case (nxt_sel)
            SEL_PHYS: begin
                nxt_bitmap = NUM_PORTS'(1) << arrival_port;
            end
            SEL_LOOP: begin
                nxt_bitmap = NUM_PORTS'(1) << loop_port;
            end
            SEL_MASQ: begin
                nxt_bitmap = NUM_PORTS'(1) << masq_port;
            end
            SEL_SRC: begin
                // everything not set below stays zero
                nxt_bitmap[SEL3_PROC_A_BIT] = is_processor_port_a;
                nxt_bitmap[SEL3_PROC_B_BIT] = is_processor_port_b;
                nxt_bitmap[SEL3_VDEV_A_BIT] = is_virtual_device_a;
                nxt_bitmap[SEL3_VDEV_B_BIT] = is_virtual_device_b;
                nxt_bitmap[SEL3_SRC_LO +: PORT_NUM_W] =
                    is_masqueraded ? masq_port : arrival_port;
                nxt_bitmap[SEL3_PT_LO +: PIPE_PT_W] = pipeline_point;
                nxt_bitmap[SEL3_ACT_LO +: PIPE_ACT_W] =
                    pipeline_action;
            end
            default: begin
                nxt_bitmap = '0;
            end
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : tag_g
            tag_proto_coder u_coder (
                .present(tag_present[g]),
                .tpid(tag_tpid[g*ETYPE_W +: ETYPE_W]),
                .custom1(custom_tag1),
                .custom2(custom_tag2),
                .custom3(custom_tag3),
                .code(code[g])
            );
            assign tag_pcp[g] = tag_tci[g*ETYPE_W + TCI_PCP_LO +: PCP_W];
            assign tag_dei[g] = tag_tci[g*ETYPE_W + TCI_DEI_BIT];
            assign tag_vid[g] = tag_tci[g*ETYPE_W + TCI_VID_LO +: VID_W];
        end
    endgenerate

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            key_valid <= 1'b0;
        end else begin
            key_valid <= frame_valid;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port_bitmap_selector <= SEL_PHYS;
            ingress_port_bitmap <= '0;
        end else if (frame_valid) begin
            port_bitmap_selector <= nxt_sel;
            ingress_port_bitmap <= nxt_bitmap;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dest_mac_group_flag <= 1'b0;
            dest_mac_all_ones_flag <= 1'b0;
            dest_mac_field <= '0;
            source_mac_field <= '0;
            ip_group_dest_flag <= 1'b0;
            type_encoded_flag <= 1'b0;
        end else if (frame_valid) begin
            dest_mac_group_flag <= frame_dmac[MAC_GROUP_BIT];
            dest_mac_all_ones_flag <= &frame_dmac;
            dest_mac_field <= frame_dmac;
            source_mac_field <= frame_smac;
            ip_group_dest_flag <=
                (frame_is_ipv4 && ip_dest_top_byte[7:4] == IP4_MC_NIBBLE) ||
                (frame_is_ipv6 && ip_dest_top_byte == IP6_MC_BYTE);
            type_encoded_flag <= (type_length >= ETYPE_MIN);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            outer_tag_proto_code <= PROTO_NONE;
            outer_tag_priority <= '0;
            outer_tag_drop_eligible <= 1'b0;
            outer_tag_vlan_id <= '0;
        end else if (frame_valid) begin
            outer_tag_proto_code <= code[0];
            if (use_classified_outer_tci) begin
                outer_tag_priority <= classified_priority;
                outer_tag_drop_eligible <= classified_drop_eligible;
            end else begin
                outer_tag_priority <= tag_pcp[0];
                outer_tag_drop_eligible <= tag_dei[0];
            end
            // zero wins for untagged frames even with classified values
            if (!tag_present[0]) begin
                outer_tag_vlan_id <= '0;
            end else if (use_classified_outer_tci) begin
                outer_tag_vlan_id <= classified_vlan_id;
            end else begin
                outer_tag_vlan_id <= tag_vid[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            second_tag_proto_code <= PROTO_NONE;
            second_tag_priority <= '0;
            second_tag_drop_eligible <= 1'b0;
            second_tag_vlan_id <= '0;
            third_tag_proto_code <= PROTO_NONE;
            third_tag_priority <= '0;
            third_tag_drop_eligible <= 1'b0;
            third_tag_vlan_id <= '0;
        end else if (frame_valid) begin
            second_tag_proto_code <= code[1];
            second_tag_priority <= tag_pcp[1];
            second_tag_drop_eligible <= tag_dei[1];
            second_tag_vlan_id <= tag_vid[1];
            third_tag_proto_code <= code[2];
            third_tag_priority <= tag_pcp[2];
            third_tag_drop_eligible <= tag_dei[2];
            third_tag_vlan_id <= tag_vid[2];
        end
    end
endmodule
`default_nettype wire

// File: fkb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fkb_chk #(
    parameter int NUM_PORTS = 53
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // frame side
    input wire logic frame_valid,
    input wire logic from_loopback,
    input wire logic loop_sel3_ena,
    input wire logic [2:0] tag_present,
    input wire logic [47:0] frame_dmac,
    input wire logic [15:0] type_length,
    // key side
    input wire logic key_valid,
    input wire key_field_pkg::bitmap_sel_t port_bitmap_selector,
    input wire logic [NUM_PORTS-1:0] ingress_port_bitmap,
    input wire logic dest_mac_group_flag,
    input wire logic dest_mac_all_ones_flag,
    input wire logic [11:0] outer_tag_vlan_id,
    input wire logic [47:0] dest_mac_field,
    input wire logic type_encoded_flag
);
    import key_field_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_taken;
        frame_valid;
    endsequence
    sequence s_key;
        key_valid;
    endsequence
    a_key_follows: assert property (s_taken |=> s_key)
        else $error("key late");
    a_dmac_copy: assert property (
        s_taken |=> dest_mac_field == $past(frame_dmac))
        else $error("dmac wrong");
    a_group_bit: assert property (
        s_key |-> dest_mac_group_flag == dest_mac_field[40])
        else $error("group flag wrong");
    a_bcast_all: assert property (
        s_key |-> dest_mac_all_ones_flag == (&dest_mac_field))
        else $error("bcast flag wrong");
    a_type_len: assert property (
        s_taken |=> type_encoded_flag == ($past(type_length) >= 16'h0600))
        else $error("type flag wrong");
    a_untag_vid: assert property (
        s_taken ##0 !tag_present[0] |=> outer_tag_vlan_id == 12'h000)
        else $error("untagged vid nonzero");
    a_sel3_wins: assert property (
        s_taken ##0 (from_loopback && loop_sel3_ena)
        |=> port_bitmap_selector == SEL_SRC)
        else $error("selector not highest");
    a_sel3_zero: assert property (
        s_key ##0 port_bitmap_selector == SEL_SRC
        |-> ingress_port_bitmap[43:10] == '0 && !ingress_port_bitmap[52])
        else $error("unused bits set");
endmodule
bind frame_key_field_builder fkb_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (
    .mclk, .reset_n, .frame_valid, .from_loopback, .loop_sel3_ena,
    .tag_present, .frame_dmac, .type_length, .key_valid,
    .port_bitmap_selector, .ingress_port_bitmap, .dest_mac_group_flag,
    .dest_mac_all_ones_flag, .outer_tag_vlan_id, .dest_mac_field,
    .type_encoded_flag);
`default_nettype wire

// File: key_sink.sv
`timescale 1ns/1ps
`default_nettype none
module key_sink (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // key strobe from builder
    input wire logic key_valid,
    // keys consumed so far
    output logic [15:0] keys_ff
);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            keys_ff <= 16'h0000;
        end else if (key_valid) begin
            keys_ff <= keys_ff + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import key_field_pkg::*;
    typedef struct packed {
        bitmap_sel_t sel;
        logic [52:0] bm;
        logic mc, bc, ip, et;
        logic [2:0] c0, c1, c2;
        logic [15:0] t0, t1, t2;
        logic [47:0] dm, sm;
    } exp_t;
    logic mclk, reset_n, frame_valid, from_loopback, is_masqueraded;
    logic is_injected, from_virtual_device, is_processor_port_a;
    logic is_processor_port_b, is_virtual_device_a, is_virtual_device_b;
    logic masq_bitmap_ena, proc_bitmap_ena, vdev_bitmap_ena, loop_sel3_ena;
    logic use_classified_outer_tci, classified_drop_eligible;
    logic frame_is_ipv4, frame_is_ipv6, key_valid, ip_group_dest_flag;
    logic [5:0] arrival_port, loop_port, masq_port;
    logic [4:0] pipeline_point;
    logic [2:0] pipeline_action, tag_present, classified_priority;
    logic [15:0] custom_tag1, custom_tag2, custom_tag3, type_length, keys;
    logic [47:0] frame_dmac, frame_smac, tag_tpid, tag_tci;
    logic [47:0] dest_mac_field, source_mac_field;
    logic [11:0] classified_vlan_id, outer_tag_vlan_id;
    logic [11:0] second_tag_vlan_id, third_tag_vlan_id;
    logic [7:0] ip_dest_top_byte;
    bitmap_sel_t port_bitmap_selector;
    logic [52:0] ingress_port_bitmap;
    logic dest_mac_group_flag, dest_mac_all_ones_flag, type_encoded_flag;
    logic outer_tag_drop_eligible, second_tag_drop_eligible;
    logic third_tag_drop_eligible;
    logic [2:0] outer_tag_proto_code, second_tag_proto_code;
    logic [2:0] third_tag_proto_code, outer_tag_priority;
    logic [2:0] second_tag_priority, third_tag_priority;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int frames = 0;
    logic [31:0] x = 32'h00000050;
    logic [15:0] tp [8] = '{16'h8100, 16'h88a8, 16'h9100, 16'h9200,
        16'h9300, 16'h0800, 16'h8100, 16'h88a8};
    exp_t q[$];
    exp_t m;

    frame_key_field_builder dut (
        .mclk, .reset_n, .frame_valid, .arrival_port, .loop_port, .masq_port,
        .from_loopback, .is_masqueraded, .is_injected, .from_virtual_device,
        .is_processor_port_a, .is_processor_port_b, .is_virtual_device_a,
        .is_virtual_device_b, .pipeline_point, .pipeline_action,
        .masq_bitmap_ena, .proc_bitmap_ena, .vdev_bitmap_ena, .loop_sel3_ena,
        .use_classified_outer_tci, .custom_tag1, .custom_tag2, .custom_tag3,
        .frame_dmac, .frame_smac, .tag_present, .tag_tpid, .tag_tci,
        .classified_priority, .classified_drop_eligible, .classified_vlan_id,
        .frame_is_ipv4, .frame_is_ipv6, .ip_dest_top_byte, .type_length,
        .key_valid, .port_bitmap_selector, .ingress_port_bitmap,
        .dest_mac_group_flag, .dest_mac_all_ones_flag, .outer_tag_proto_code,
        .outer_tag_priority, .outer_tag_drop_eligible, .outer_tag_vlan_id,
        .second_tag_proto_code, .second_tag_priority,
        .second_tag_drop_eligible, .second_tag_vlan_id,
        .third_tag_proto_code, .third_tag_priority,
        .third_tag_drop_eligible, .third_tag_vlan_id, .dest_mac_field,
        .source_mac_field, .ip_group_dest_flag, .type_encoded_flag);
    key_sink sink (.mclk, .reset_n, .key_valid, .keys_ff(keys));

    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    function automatic logic [2:0] code(input logic p, input logic [15:0] t);
        if (!p) return 3'h0;
        if (t == 16'h8100) return 3'h1;
        if (t == 16'h88a8) return 3'h4;
        if (t == custom_tag1) return 3'h5;
        if (t == custom_tag2) return 3'h6;
        if (t == custom_tag3) return 3'h7;
        return 3'h0;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // fields are rerolled every cycle so an idle cycle never looks stale
    task automatic drive(input logic v);
        logic [31:0] r;
        logic [5:0] p;
        exp_t e;
        r = rnd();
        frame_valid = v;
        {from_loopback, is_masqueraded, is_injected, from_virtual_device,
            is_processor_port_a, is_processor_port_b, is_virtual_device_a,
            is_virtual_device_b, masq_bitmap_ena, proc_bitmap_ena,
            vdev_bitmap_ena, loop_sel3_ena, use_classified_outer_tci,
            classified_drop_eligible, frame_is_ipv4, frame_is_ipv6,
            tag_present} = r[18:0];
        r = rnd();
        {arrival_port, loop_port, masq_port, pipeline_point,
            pipeline_action} = r[25:0];
        r = rnd();
        frame_dmac = r[31:30] == 2'h0 ? 48'hffffffffffff : {r[15:0], rnd()};
        frame_smac = {rnd(), r[31:16]};
        tag_tpid = {tp[r[2:0]], tp[r[5:3]], tp[r[8:6]]};
        r = rnd();
        tag_tci = {r[15:0], rnd()};
        {classified_priority, classified_vlan_id} = r[30:16];
        r = rnd();
        ip_dest_top_byte = r[0] ? 8'hff : {r[1] ? 4'he : r[7:4], r[11:8]};
        type_length = r[12] ? 16'h05ff + {15'h0, r[14]} : r[31:16];
        if (v) begin
            e.sel = (is_injected & proc_bitmap_ena)
                | (from_virtual_device & vdev_bitmap_ena)
                | (from_loopback & loop_sel3_ena) ? SEL_SRC
                : (is_masqueraded & masq_bitmap_ena) ? SEL_MASQ
                : from_loopback ? SEL_LOOP : SEL_PHYS;
            p = e.sel == SEL_LOOP ? loop_port
                : e.sel == SEL_MASQ ? masq_port : arrival_port;
            e.bm = p < 6'd53 ? 53'h1 << p : 53'h0;
            if (e.sel == SEL_SRC) begin
                e.bm = {1'b0, pipeline_action, pipeline_point, 34'h0,
                    is_masqueraded ? masq_port : arrival_port,
                    is_virtual_device_b, is_virtual_device_a,
                    is_processor_port_b, is_processor_port_a};
            end
            e.mc = frame_dmac[40];
            e.bc = &frame_dmac;
            e.dm = frame_dmac;
            e.sm = frame_smac;
            e.c0 = code(tag_present[0], tag_tpid[15:0]);
            e.c1 = code(tag_present[1], tag_tpid[31:16]);
            e.c2 = code(tag_present[2], tag_tpid[47:32]);
            e.t0 = use_classified_outer_tci ? {classified_priority,
                classified_drop_eligible, classified_vlan_id} : tag_tci[15:0];
            if (!tag_present[0]) e.t0[11:0] = 12'h000;
            e.t1 = tag_tci[31:16];
            e.t2 = tag_tci[47:32];
            e.ip = (frame_is_ipv4 & ip_dest_top_byte[7:4] == 4'he)
                | (frame_is_ipv6 & ip_dest_top_byte == 8'hff);
            e.et = type_length >= 16'h0600;
            q.push_back(e);
            frames++;
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(negedge mclk) begin
        if (key_valid === 1'b1) begin
            if (q.size() == 0) begin
                chk(1, 0);
            end else begin
                m = q.pop_front();
                chk(port_bitmap_selector, m.sel);
                chk(ingress_port_bitmap, m.bm);
                chk(dest_mac_group_flag, m.mc);
                chk(dest_mac_all_ones_flag, m.bc);
                chk(outer_tag_proto_code, m.c0);
                chk(second_tag_proto_code, m.c1);
                chk(third_tag_proto_code, m.c2);
                chk(outer_tag_priority, m.t0[15:13]);
                chk(outer_tag_drop_eligible, m.t0[12]);
                chk(outer_tag_vlan_id, m.t0[11:0]);
                chk(second_tag_priority, m.t1[15:13]);
                chk(second_tag_drop_eligible, m.t1[12]);
                chk(second_tag_vlan_id, m.t1[11:0]);
                chk(third_tag_priority, m.t2[15:13]);
                chk(third_tag_drop_eligible, m.t2[12]);
                chk(third_tag_vlan_id, m.t2[11:0]);
                chk(dest_mac_field, m.dm);
                chk(source_mac_field, m.sm);
                chk(ip_group_dest_flag, m.ip);
                chk(type_encoded_flag, m.et);
            end
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            finish_test();
        end
    end

    initial begin
        reset_n = 1'b0;
        custom_tag1 = 16'h9100;
        custom_tag2 = 16'h9200;
        custom_tag3 = 16'h9300;
        drive(1'b0);
        repeat (12) @(posedge mclk);
        #2 reset_n = 1'b1;
        repeat (3000) begin
            @(posedge mclk);
            #2 drive((rnd() & 32'h3) != 32'h0);
        end
        @(posedge mclk);
        #2 drive(1'b0);
        repeat (3) @(posedge mclk);
        chk(keys, frames);
        chk(q.size(), 0);
        finish_test();
    end
endmodule
`default_nettype wire
